//--- logic/pli_pkg.sv
// Package for the indicator and interrupt control block.
// Assumes a 5-bit register address and 16-bit register data.
package pli_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned EVT_N  = 11;
  localparam int unsigned MODE_W = 3;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_IND_CFG  = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_RSV_CTRL = 5'h15;
  localparam logic [ADDR_W-1:0] ADDR_INT_CTRL = 5'h16;
  localparam logic [ADDR_W-1:0] ADDR_INT_FLAG = 5'h17;

  // Reset values
  localparam logic [DATA_W-1:0] RST_IND_CFG  = 16'h3fe9;
  localparam logic [DATA_W-1:0] RST_RSV_CTRL = 16'h0000;
  localparam logic [DATA_W-1:0] RST_INT_CTRL = 16'h0000;

  // Field positions
  localparam int unsigned MODE_B_LSB  = 3;
  localparam int unsigned MODE_A_LSB  = 0;
  localparam int unsigned BIT_OUT_EN  = 15;
  localparam int unsigned BIT_RD_CLR  = 14;
  localparam int unsigned BIT_POL     = 13;
  localparam int unsigned BIT_AUTO    = 12;
  localparam int unsigned BIT_RESETUP = 11;

  // Indicator source codes
  typedef enum logic [MODE_W-1:0] {
    PLI_LINK   = 3'b000,
    PLI_ACT    = 3'b001,
    PLI_TX     = 3'b010,
    PLI_RX     = 3'b011,
    PLI_COL    = 3'b100,
    PLI_SPEED  = 3'b101,
    PLI_DUPLEX = 3'b110,
    PLI_LAST   = 3'b111
  } pli_mode_e;
endpackage

//--- logic/pli_flag_if.sv
// Interface between the register logic and the event flag bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pli_flag_if;
  import pli_pkg::*;
  logic [EVT_N-1:0] cond;
  logic [EVT_N-1:0] wr_clr;
  logic [EVT_N-1:0] flags;
  logic             rd_clr;
  logic             auto_clr;
  logic             resetup;
  modport ctrl (output cond, wr_clr, rd_clr, auto_clr, resetup,
                input flags);
  modport bank (input cond, wr_clr, rd_clr, auto_clr, resetup,
                output flags);
endinterface

//--- logic/pli_flag_bank.sv
// Sticky event flags with read, write-one and automatic clearing.
// Assumes event conditions are levels from logic on the same clock.
`timescale 1ns/1ps
module pli_flag_bank
  import pli_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control side
  pli_flag_if.bank  fb
);
  typedef struct packed {
    logic [EVT_N-1:0] prev;
    logic [EVT_N-1:0] flags;
  } pli_bank_s;

  pli_bank_s        st_r;
  pli_bank_s        st_nxt;
  logic [EVT_N-1:0] rise;
  logic [EVT_N-1:0] flag_nxt;

  // Per-flag next value; a new event wins over any clear
  genvar i;
  generate
    for (i = 0; i < EVT_N; i++) begin : g_flag
      logic clr;
      assign rise[i] = fb.cond[i] & ~st_r.prev[i];
      assign clr = fb.rd_clr
                 | (fb.wr_clr[i] & ~(fb.resetup & fb.cond[i]))
                 | (fb.auto_clr & ~fb.cond[i]);
      assign flag_nxt[i] = rise[i] | (st_r.flags[i] & ~clr);
    end
  endgenerate

  // Next state
  always_comb begin
    st_nxt       = st_r;
    st_nxt.prev  = fb.cond;
    st_nxt.flags = flag_nxt;
  end

  // State register, flags clear at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fb.flags = st_r.flags;

  a_read_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    fb.rd_clr && (rise == '0) |=> fb.flags == '0)
    else $error("flags not cleared by read");

  a_auto_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    fb.auto_clr && (fb.cond == '0) |=> fb.flags == '0)
    else $error("flags not cleared when condition gone");

  a_resetup_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    fb.resetup && !fb.rd_clr && !fb.auto_clr
      && ((fb.wr_clr & fb.cond & fb.flags) != '0)
    |=> (fb.flags & $past(fb.wr_clr & fb.cond & fb.flags))
        == $past(fb.wr_clr & fb.cond & fb.flags))
    else $error("flag lost on write while condition present");

  a_write_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    !fb.resetup && (fb.wr_clr != '0)
    |=> (fb.flags & $past(fb.wr_clr & ~rise)) == '0)
    else $error("flag not cleared by write of one");

  a_set_wins: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rise != '0) |=> (fb.flags & $past(rise)) == $past(rise))
    else $error("event lost");
endmodule // pli_flag_bank

//--- logic/pli_ctrl.sv
// Indicator source selection and interrupt pin control, with the
// register file behind the management interface.
// Assumes the management frame decoder gives one-cycle read and write
// strobes on this clock, and that status and event inputs come from
// logic on the same clock.
//
// How it works
// - Indicator b shows the source chosen by a 3-bit code, 111 is off.
// - Indicator a uses the same codes, 111 shows link state, reset 001.
// - The interrupt pin is driven only while enabled, level by polarity.
// - With read-clear on, reading the flag register clears the flags.
// - Writing one clears a flag unless re-setup holds it while active.
// - Enables for wake-up, power-down entry and negotiation done.
// - Lower enables cover the eight link and negotiation events.
// - Each event has a sticky flag, cleared by writing one, at its enable position.
`timescale 1ns/1ps
module pli_ctrl
  import pli_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Management register access
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  // Indicator sources
  input  wire logic              link_ok,
  input  wire logic              activity,
  input  wire logic              tx_active,
  input  wire logic              rx_active,
  input  wire logic              collision,
  input  wire logic              speed_100,
  input  wire logic              full_duplex,
  input  wire logic              link_state,
  // Event conditions, one per flag
  input  wire logic [EVT_N-1:0]  evt_cond,
  // Indicator outputs
  output logic                   indicator_out_a,
  output logic                   indicator_out_b,
  // Interrupt pin
  output logic                   irq_pin,
  output logic                   irq_oe
);
  typedef struct packed {
    logic [DATA_W-1:0] ind_cfg;
    logic [DATA_W-1:0] rsv_ctrl;
    logic [DATA_W-1:0] int_ctrl;
    logic [DATA_W-1:0] rdata;
    logic              led_a;
    logic              led_b;
  } pli_ctrl_s;

  pli_ctrl_s         st_r;
  pli_ctrl_s         st_nxt;
  logic [7:0]        src_vec;
  logic [EVT_N-1:0]  int_en;
  logic [EVT_N-1:0]  flags_full;
  logic              pending;
  logic              wr_cfg;
  logic              wr_int;
  logic              wr_flag;
  logic              rd_flag;
  pli_mode_e         mode_a;
  pli_mode_e         mode_b;

  pli_flag_if fb ();

  // Flag bank
  pli_flag_bank u_bank (
    .clk   (clk),
    .rst_n (rst_n),
    .fb    (fb)
  );

  // Address decode
  assign wr_cfg  = reg_wr && (reg_addr == ADDR_IND_CFG);
  assign wr_int  = reg_wr && (reg_addr == ADDR_INT_CTRL);
  assign wr_flag = reg_wr && (reg_addr == ADDR_INT_FLAG);
  assign rd_flag = reg_rd && (reg_addr == ADDR_INT_FLAG);

  // Flag bank controls
  assign fb.cond     = evt_cond;
  assign fb.rd_clr   = rd_flag && st_r.int_ctrl[BIT_RD_CLR];
  assign fb.auto_clr = st_r.int_ctrl[BIT_AUTO];
  assign fb.resetup  = st_r.int_ctrl[BIT_RESETUP];
  assign fb.wr_clr   = wr_flag ? reg_wdata[EVT_N-1:0] : '0;

  // Source vector indexed by mode code
  assign src_vec = {link_state, full_duplex, speed_100, collision,
                    rx_active, tx_active, activity, link_ok};
  assign mode_a  = pli_mode_e'(st_r.ind_cfg[MODE_A_LSB +: MODE_W]);
  assign mode_b  = pli_mode_e'(st_r.ind_cfg[MODE_B_LSB +: MODE_W]);

  // Per-event enables share bit positions with the flags
  assign int_en     = st_r.int_ctrl[EVT_N-1:0];
  assign flags_full = fb.flags;
  assign pending    = |(flags_full & int_en);

  // Next state: register writes, read data and indicator selection
  always_comb begin
    st_nxt = st_r;
    if (wr_cfg) begin
      st_nxt.ind_cfg = reg_wdata;
    end
    if (reg_wr && (reg_addr == ADDR_RSV_CTRL)) begin
      st_nxt.rsv_ctrl = reg_wdata;
    end
    if (wr_int) begin
      st_nxt.int_ctrl = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_IND_CFG:  st_nxt.rdata = st_r.ind_cfg;
        ADDR_RSV_CTRL: st_nxt.rdata = st_r.rsv_ctrl;
        ADDR_INT_CTRL: st_nxt.rdata = st_r.int_ctrl;
        ADDR_INT_FLAG: st_nxt.rdata = DATA_W'(fb.flags);
        default:       st_nxt.rdata = '0;
      endcase
    end
    // Indicator a: code 111 shows link state
    case (mode_a)
      PLI_LAST: st_nxt.led_a = link_state;
      default:  st_nxt.led_a = src_vec[mode_a];
    endcase
    // Indicator b: code 111 turns it off
    case (mode_b)
      PLI_LAST: st_nxt.led_b = 1'b0;
      default:  st_nxt.led_b = src_vec[mode_b];
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.ind_cfg  <= RST_IND_CFG;
      st_r.rsv_ctrl <= RST_RSV_CTRL;
      st_r.int_ctrl <= RST_INT_CTRL;
      st_r.rdata    <= '0;
      st_r.led_a    <= 1'b0;
      st_r.led_b    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata       = st_r.rdata;
  assign indicator_out_a = st_r.led_a;
  assign indicator_out_b = st_r.led_b;
  assign irq_oe = st_r.int_ctrl[BIT_OUT_EN];
  // Asserted level follows polarity; idle level is its inverse
  assign irq_pin = pending ~^ st_r.int_ctrl[BIT_POL];

  // Write sequences used by the assertions
  sequence s_cfg_b_off;
    wr_cfg && (reg_wdata[MODE_B_LSB +: MODE_W] == PLI_LAST);
  endsequence
  sequence s_cfg_a_last;
    wr_cfg && (reg_wdata[MODE_A_LSB +: MODE_W] == PLI_LAST);
  endsequence

  a_led_b_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_cfg_b_off ##1 !wr_cfg |=> !indicator_out_b)
    else $error("indicator b not off for code 111");

  a_led_a_link: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_cfg_a_last ##1 !wr_cfg |=> indicator_out_a == $past(link_state))
    else $error("indicator a not showing link state");

  a_led_b_src: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode_b == PLI_TX |=> indicator_out_b == $past(tx_active))
    else $error("indicator b not showing transmit");

  a_led_a_src: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode_a == PLI_ACT |=> indicator_out_a == $past(activity))
    else $error("indicator a not showing activity");

  a_irq_enable: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_int |=> irq_oe == $past(reg_wdata[BIT_OUT_EN]))
    else $error("pin enable does not follow control write");

  a_irq_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    (flags_full & int_en) == '0 |-> irq_pin == !st_r.int_ctrl[BIT_POL])
    else $error("pin asserted with no enabled flag");

  a_irq_active: assert property (
    @(posedge clk) disable iff (!rst_n)
    (flags_full & int_en) != '0 |-> irq_pin == st_r.int_ctrl[BIT_POL])
    else $error("pin not at asserted level with enabled flag");

  a_irq_event: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_int && reg_wdata[0] && (reg_wdata[BIT_POL] == 1'b1)
      ##1 (evt_cond[0] && !$past(evt_cond[0]) && !wr_int
           && !rd_flag && !wr_flag)
    |=> irq_pin)
    else $error("pin not asserted after enabled event");

  a_rd_flags: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_flag |=> reg_rdata == DATA_W'($past(fb.flags)))
    else $error("flag read data wrong");

  a_rd_unmapped: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && (reg_addr < ADDR_IND_CFG) |=> reg_rdata == '0)
    else $error("unmapped read not zero");

  a_rd_keep: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_flag && !st_r.int_ctrl[BIT_RD_CLR] && !st_r.int_ctrl[BIT_AUTO]
      && !wr_flag
    |=> (fb.flags & $past(fb.flags)) == $past(fb.flags))
    else $error("read changed flags with read clear off");
endmodule // pli_ctrl

//--- verif/pli_sta_model.sv
// Station management side model: register accesses to the block.
// Assumes the bench calls wr and rd; strobes change at falling edges.
`timescale 1ns/1ps
module pli_sta_model
  import pli_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Register access
  output logic      [ADDR_W-1:0] reg_addr,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic      [DATA_W-1:0] reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr  = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = '0;
  end

  // One-cycle write strobe; data is scrambled once the strobe drops
  task automatic wr(input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // One-cycle read strobe; data is taken at the next falling edge, half a cycle after the read edge
  task automatic rd(input logic [ADDR_W-1:0] a,
                    output logic [DATA_W-1:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask
endmodule // pli_sta_model

//--- verif/tb.sv
// Self-checking bench for the indicator and interrupt control block.
// Assumes the management model drives the register port.
`timescale 1ns/1ps
module tb;
  import pli_pkg::*;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic [7:0]        src;
  logic [EVT_N-1:0]  evt_cond;
  logic              ind_a;
  logic              ind_b;
  logic              irq_o;
  logic              irq_oe;
  logic [DATA_W-1:0] v;
  int                error_cnt;
  int                total_checks;
  int                seed;

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  pli_sta_model u_pli_sta_model (.clk(clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  pli_ctrl u_pli_ctrl (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .link_ok(src[0]), .activity(src[1]),
    .tx_active(src[2]), .rx_active(src[3]), .collision(src[4]),
    .speed_100(src[5]), .full_duplex(src[6]), .link_state(src[7]),
    .evt_cond(evt_cond), .indicator_out_a(ind_a),
    .indicator_out_b(ind_b), .irq_pin(irq_o), .irq_oe(irq_oe));

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Expected indicator level; code 111 differs per output
  function automatic logic exp_ind(logic [2:0] c, logic b_side);
    if (c == 3'b111)
      return b_side ? 1'b0 : src[7];
    return src[c];
  endfunction

  // Expected pin level from polarity and pending state
  function automatic logic exp_irq(logic pol, logic act);
    return act ? pol : ~pol;
  endfunction

  // Raise or drop one event condition at a falling edge
  task automatic cond(input int i, input logic val);
    @(negedge clk);
    evt_cond[i] = val;
  endtask

  // Watchdog
  initial begin
    #100us;
    error_cnt++;
    end_sim();
  end

  // Main sequence
  initial begin
    seed = 32'h0ef0_2ffe;
    error_cnt = 0;
    total_checks = 0;
    rst_n = 1'b0;
    src = '0;
    evt_cond = '0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    chk(irq_oe, 0);
    chk(irq_o, 1);
    u_pli_sta_model.rd(ADDR_IND_CFG, v);
    chk(v, RST_IND_CFG);
    u_pli_sta_model.rd(ADDR_RSV_CTRL, v);
    chk(v, 16'h0000);
    u_pli_sta_model.rd(ADDR_INT_CTRL, v);
    chk(v, 16'h0000);
    u_pli_sta_model.rd(ADDR_INT_FLAG, v);
    chk(v, 16'h0000);
    u_pli_sta_model.rd(5'h00, v);
    chk(v, 16'h0000);
    // Every code pair with random sources
    for (int i = 0; i < 64; i++) begin
      v = 16'($random(seed));
      v[5:0] = i[5:0];
      u_pli_sta_model.wr(ADDR_IND_CFG, v);
      src = 8'($random(seed));
      @(negedge clk);
      chk(ind_a, exp_ind(v[2:0], 1'b0));
      chk(ind_b, exp_ind(v[5:3], 1'b1));
    end
    // Each event alone enabled; a neighbour fires but is masked
    for (int i = 0; i < EVT_N; i++) begin
      u_pli_sta_model.wr(ADDR_INT_CTRL, 16'h8000 | (i[0] << 13) | (1 << i));
      cond((i + 1) % EVT_N, 1'b1);
      @(negedge clk);
      chk(irq_o, exp_irq(i[0], 1'b0));
      cond(i, 1'b1);
      @(negedge clk);
      chk(irq_o, exp_irq(i[0], 1'b1));
      chk(irq_oe, 1);
      u_pli_sta_model.rd(ADDR_INT_FLAG, v);
      chk(v, (1 << i) | (1 << ((i + 1) % EVT_N)));
      u_pli_sta_model.wr(ADDR_INT_FLAG, 16'hffff);
      u_pli_sta_model.rd(ADDR_INT_FLAG, v);
      chk(v, 16'h0000);
      chk(irq_o, exp_irq(i[0], 1'b0));
      evt_cond = '0;
    end
    // Read clear
    u_pli_sta_model.wr(ADDR_INT_CTRL, 16'hc001);
    cond(0, 1'b1);
    u_pli_sta_model.rd(ADDR_INT_FLAG, v);
    chk(v, 16'h0001);
    u_pli_sta_model.rd(ADDR_INT_FLAG, v);
    chk(v, 16'h0000);
    cond(0, 1'b0);
    // Re-setup holds while the condition stays; no auto clear
    u_pli_sta_model.wr(ADDR_INT_CTRL, 16'h8801);
    cond(0, 1'b1);
    u_pli_sta_model.wr(ADDR_INT_FLAG, 16'h0001);
    u_pli_sta_model.rd(ADDR_INT_FLAG, v);
    chk(v, 16'h0001);
    cond(0, 1'b0);
    u_pli_sta_model.rd(ADDR_INT_FLAG, v);
    chk(v, 16'h0001);
    u_pli_sta_model.wr(ADDR_INT_FLAG, 16'h0001);
    u_pli_sta_model.rd(ADDR_INT_FLAG, v);
    chk(v, 16'h0000);
    // Auto clear, then pin disabled with a pending flag
    u_pli_sta_model.wr(ADDR_INT_CTRL, 16'h9001);
    cond(0, 1'b1);
    @(negedge clk);
    chk(irq_o, exp_irq(1'b0, 1'b1));
    cond(0, 1'b0);
    @(negedge clk);
    chk(irq_o, exp_irq(1'b0, 1'b0));
    u_pli_sta_model.wr(ADDR_INT_CTRL, 16'h0001);
    cond(0, 1'b1);
    @(negedge clk);
    chk(irq_oe, 0);
    u_pli_sta_model.rd(ADDR_INT_CTRL, v);
    chk(v, 16'h0001);
    // High polarity: event rises in the cycle right after the write
    cond(0, 1'b0);
    u_pli_sta_model.wr(ADDR_INT_FLAG, 16'h0001);
    u_pli_sta_model.wr(ADDR_INT_CTRL, 16'ha001);
    evt_cond[0] = 1'b1;
    @(negedge clk);
    chk(irq_o, exp_irq(1'b1, 1'b1));
    @(negedge clk);
    chk(irq_oe, 1);
    chk(irq_o, exp_irq(1'b1, 1'b1));
    end_sim();
  end
endmodule // tb
